//--- hw/spm_port.sv
// Byte-wide serial peripheral port, master or slave, with two SFRs
// Summary of operation
// - One byte each way, MSB first
// - Input data line in master, drive in slave
// - Drive output data line in master only
// - Clock driven as master, input as slave
// - One bit per clock, eight per byte
// - Launch one edge, sample the other
// - Slave shifts only while select low
// - Far master frames select per byte
// - Slave reads select level on rate bit
// - Done flag set, cleared by write/read
// - Write during transfer sets collision flag
// - Enable bit gives pins to this port
// - Role bit picks master or slave
// - Polarity bit sets idle clock level
// - Phase bit picks launching edge
// - Master rate is clock/2,4,8,16
// - Data write sends, read returns received
// - Both ends share polarity and phase
// - Master write starts eight clock pulses
// - Received byte copied only when complete
// - Slave ends on eighth clock or select
// - Master ignores the select pin
`timescale 1ns/1ps
`default_nettype none
module spm_port (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // SFR access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Pin ownership for the shared pin mux
  output logic spi_owns_pins,
  // Link
  spm_link_if.dev link
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sck_s1, sck_s2, sck_d;
  logic ss_s1, ss_s2;
  logic mi_s1, mi_s2;
  logic mo_s1, mo_s2;
  // Two flops per pin; sck_d only delays the second flop for edges
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d <= 1'b0;
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      mi_s1 <= 1'b0;
      mi_s2 <= 1'b0;
      mo_s1 <= 1'b0;
      mo_s2 <= 1'b0;
    end
    else if (ce)
    begin
      sck_s1 <= link.sclk;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      ss_s1 <= link.ss_n;
      ss_s2 <= ss_s1;
      mi_s1 <= link.miso;
      mi_s2 <= mi_s1;
      mo_s1 <= link.mosi;
      mo_s2 <= mo_s1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Registers and engine state
  logic [7:0] ctl_r, ctl_nxt;    // Control register
  logic [7:0] dat_r, dat_nxt;    // Received byte as seen by software
  logic [7:0] sh_r, sh_nxt;      // Shift register
  logic [7:0] rd_r, rd_nxt;      // Registered read data
  logic [2:0] cnt_r, cnt_nxt;    // Bits done in this byte
  logic [3:0] hc_r, hc_nxt;      // Half period counter
  logic sck_r, sck_nxt;          // Master clock level
  logic out_r, out_nxt;          // Launched bit for phase 1
  logic lat_r, lat_nxt;          // Sampled bit for phase 0
  spm_pkg::spm_state_t st_r, st_nxt;
  // Control fields
  logic interface_select_enable, master, cpol, cpha;
  logic [1:0] rate;
  assign interface_select_enable = ctl_r[spm_pkg::BIT_SPE];
  assign master = ctl_r[spm_pkg::BIT_ROLE];
  assign cpol = ctl_r[spm_pkg::BIT_CPOL];
  assign cpha = ctl_r[spm_pkg::BIT_CPHA];
  assign rate = {ctl_r[spm_pkg::BIT_RATE1], ctl_r[spm_pkg::BIT_RATE0]};
  //////////////////////////////////////////////////////////////////////////////
  // Edge detection
  logic tick, lead, trail, sl_rise, sl_fall, sl_sel, din, busy;
  logic wr_dat, wr_ctl, rd_dat;
  assign tick = (st_r == spm_pkg::ST_RUN) && (hc_r == spm_pkg::spm_half_len(rate) - 4'h1);
  // slave edges count only while selected
  assign sl_sel = interface_select_enable & ~master & ~ss_s2;
  assign sl_rise = sck_s2 & ~sck_d & sl_sel;
  assign sl_fall = ~sck_s2 & sck_d & sl_sel;
  assign lead = master ? (tick & (sck_r == cpol)) : (cpol ? sl_fall : sl_rise);
  assign trail = master ? (tick & (sck_r != cpol)) : (cpol ? sl_rise : sl_fall);
  // Data input: miso as master, mosi as slave
  assign din = master ? mi_s2 : mo_s2;
  // Transfer in progress
  assign busy = master ? (st_r != spm_pkg::ST_IDLE) : (cnt_r != 3'h0 || st_r != spm_pkg::ST_IDLE);
  // Bus strobes
  assign wr_dat = sfr_wr && sfr_addr == spm_pkg::ADDR_DATA;
  assign wr_ctl = sfr_wr && sfr_addr == spm_pkg::ADDR_CTRL;
  assign rd_dat = sfr_rd && sfr_addr == spm_pkg::ADDR_DATA;
  //////////////////////////////////////////////////////////////////////////////
  // Next-value logic for registers and engine
  always_comb
  begin
    ctl_nxt = ctl_r;
    dat_nxt = dat_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    hc_nxt = hc_r;
    sck_nxt = sck_r;
    out_nxt = out_r;
    lat_nxt = lat_r;
    st_nxt = st_r;
    rd_nxt = rd_r;
    // Control write: flags may only be cleared by software
    if (wr_ctl)
    begin
      ctl_nxt[5:0] = sfr_wdata[5:0];
      ctl_nxt[spm_pkg::BIT_DONE] = ctl_r[spm_pkg::BIT_DONE] & sfr_wdata[spm_pkg::BIT_DONE];
      ctl_nxt[spm_pkg::BIT_WRITE_COLLISION_FLAG] = ctl_r[spm_pkg::BIT_WRITE_COLLISION_FLAG] & sfr_wdata[spm_pkg::BIT_WRITE_COLLISION_FLAG];
    end
    if (rd_dat)
      ctl_nxt[spm_pkg::BIT_DONE] = 1'b0;
    // Read data, captured on the read strobe
    if (sfr_rd)
    begin
      if (sfr_addr == spm_pkg::ADDR_DATA)
        rd_nxt = dat_r;
      else if (sfr_addr == spm_pkg::ADDR_CTRL)
        // slave shows select level in bit 0
        rd_nxt = {ctl_r[7:1], master ? ctl_r[spm_pkg::BIT_RATE0] : ss_s2};
      else
        rd_nxt = 8'h00;
    end
    // Data write
    if (wr_dat)
    begin
      if (busy)
      begin
        // collision flag on write while busy
        ctl_nxt[spm_pkg::BIT_WRITE_COLLISION_FLAG] = 1'b1;
      end
      else
      begin
        sh_nxt = sfr_wdata;
        out_nxt = sfr_wdata[7];
        cnt_nxt = 3'h0;
        hc_nxt = 4'h0;
        sck_nxt = cpol;
        if (master && interface_select_enable)
          st_nxt = spm_pkg::ST_RUN;
      end
    end
    // Master clock divider, toggling every half period
    if (master && st_r == spm_pkg::ST_RUN)
    begin
      hc_nxt = tick ? 4'h0 : hc_r + 4'h1;
      sck_nxt = tick ? ~sck_r : sck_r;
    end
    if (lead)
    begin
      // launch on leading edge for phase 1, else sample
      if (cpha)
        out_nxt = sh_r[7];
      else
        lat_nxt = din;
      if (!master && st_r == spm_pkg::ST_IDLE)
        st_nxt = spm_pkg::ST_RUN;
    end
    // MSB first, sampled bit enters at the bottom
    if (trail)
    begin
      sh_nxt = {sh_r[6:0], cpha ? din : lat_r};
      cnt_nxt = cnt_r + 3'h1;
      if (cnt_r == spm_pkg::LAST_BIT)
      begin
        // phase 0 slave waits for select
        if (master || cpha)
        begin
          dat_nxt = sh_nxt;
          st_nxt = spm_pkg::ST_IDLE;
          // done flag set at byte end
          ctl_nxt[spm_pkg::BIT_DONE] = 1'b1;
        end
        else
          st_nxt = spm_pkg::ST_WAIT;
      end
    end
    // select pin only matters as slave
    if (interface_select_enable && !master && ss_s2)
    begin
      if (st_r == spm_pkg::ST_WAIT)
      begin
        dat_nxt = sh_r;
        ctl_nxt[spm_pkg::BIT_DONE] = 1'b1;
      end
      // Deselect drops any partial byte
      st_nxt = spm_pkg::ST_IDLE;
      cnt_nxt = 3'h0;
    end
    if (!interface_select_enable)
    begin
      st_nxt = spm_pkg::ST_IDLE;
      cnt_nxt = 3'h0;
      sck_nxt = cpol;
    end
  end
  // Register update
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      ctl_r <= spm_pkg::CTRL_RST;
      dat_r <= spm_pkg::DATA_RST;
      sh_r <= spm_pkg::DATA_RST;
      rd_r <= 8'h00;
      cnt_r <= 3'h0;
      hc_r <= 4'h0;
      sck_r <= 1'b0;
      out_r <= 1'b0;
      lat_r <= 1'b0;
      st_r <= spm_pkg::ST_IDLE;
    end
    else if (ce)
    begin
      ctl_r <= ctl_nxt;
      dat_r <= dat_nxt;
      sh_r <= sh_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      hc_r <= hc_nxt;
      sck_r <= sck_nxt;
      out_r <= out_nxt;
      lat_r <= lat_nxt;
      st_r <= st_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  logic tx_bit;
  // Phase 0 shows the next bit at once, phase 1 after the leading edge
  assign tx_bit = cpha ? out_r : sh_r[7];
  // clock driven only as enabled master
  assign link.dev_sclk_o = (master && st_r == spm_pkg::ST_RUN) ? sck_r : cpol;
  assign link.dev_sclk_oe = interface_select_enable & master;
  assign link.dev_mosi_o = tx_bit;
  assign link.dev_mosi_oe = interface_select_enable & master;
  assign link.dev_miso_o = tx_bit;
  assign link.dev_miso_oe = interface_select_enable & ~master;
  assign spi_owns_pins = interface_select_enable;
  // Read data from flip-flops
  assign sfr_rdata = rd_r;
endmodule : spm_port
`default_nettype wire

//--- hw/spm_pkg.sv
// Shared constants, types and helpers for the serial port and its far end
package spm_pkg;
  // Special function register addresses
  localparam logic [7:0] ADDR_DATA = 8'hf7;
  localparam logic [7:0] ADDR_CTRL = 8'hf8;
  // Values after reset
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Control register field positions
  localparam int BIT_DONE = 7;
  localparam int BIT_WRITE_COLLISION_FLAG = 6;
  localparam int BIT_SPE = 5;
  localparam int BIT_ROLE = 4;
  localparam int BIT_CPOL = 3;
  localparam int BIT_CPHA = 2;
  localparam int BIT_RATE1 = 1;
  localparam int BIT_RATE0 = 0;
  // Last bit index of a byte, counted from zero
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Transfer states, Gray coded along idle, run, wait-for-select
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_WAIT = 2'h3
  } spm_state_t;
  // Half serial period in core cycles: divide by 2, 4, 8 or 16
  function automatic logic [3:0] spm_half_len(input logic [1:0] code);
    spm_half_len = 4'h1 << code;
  endfunction : spm_half_len
endpackage : spm_pkg

//--- hw/spm_link_if.sv
// Serial link wires between the port and its far end
`timescale 1ns/1ps
`default_nettype none
interface spm_link_if;
  // Drive values and enables of the port
  logic dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe;
  // Drive values and enables of the far end
  logic far_sclk_o, far_sclk_oe, far_mosi_o, far_mosi_oe, far_miso_o, far_miso_oe;
  logic far_ss_n_o, far_ss_n_oe;
  // Resolved line levels, idle lines pulled high
  logic sclk, mosi, miso, ss_n;
  assign sclk = dev_sclk_oe ? dev_sclk_o : (far_sclk_oe ? far_sclk_o : 1'b1);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe ? far_mosi_o : 1'b1);
  assign miso = dev_miso_oe ? dev_miso_o : (far_miso_oe ? far_miso_o : 1'b1);
  assign ss_n = far_ss_n_oe ? far_ss_n_o : 1'b1;
  // Port side
  modport dev (
    output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe,
    input sclk, mosi, miso, ss_n
  );
  // Far end side
  modport far (
    output far_sclk_o, far_sclk_oe, far_mosi_o, far_mosi_oe, far_miso_o, far_miso_oe,
    output far_ss_n_o, far_ss_n_oe,
    input sclk, mosi, miso
  );
endinterface : spm_link_if
`default_nettype wire

//--- hw/spm_far_end.sv
// External master or slave partner of the serial port
`timescale 1ns/1ps
`default_nettype none
module spm_far_end (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // Configuration, held stable between bytes
  input wire logic is_master,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [1:0] rate,
  input wire logic sel_n,
  // Byte request and answer
  input wire logic [7:0] tx_byte,
  input wire logic tx_load,
  output logic [7:0] rx_byte,
  output logic rx_done,
  output logic busy,
  // Link
  spm_link_if.far link
);
  //////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on link inputs
  logic sck_s1, sck_s2, sck_d, in_s1, in_s2;
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sck_s1 <= 1'b0; sck_s2 <= 1'b0; sck_d <= 1'b0; in_s1 <= 1'b0; in_s2 <= 1'b0;
    end
    else if (ce)
    begin
      sck_s1 <= link.sclk;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      in_s1 <= is_master ? link.miso : link.mosi;
      in_s2 <= in_s1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Engine state
  spm_pkg::spm_state_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt, rx_r, rx_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [3:0] hc_r, hc_nxt;
  logic sck_r, sck_nxt, out_r, out_nxt, lat_r, lat_nxt, done_r, done_nxt;
  logic tick, lead, trail, sl_rise, sl_fall;
  // Edge sources: own divider as master, synced clock as slave
  assign tick = (st_r == spm_pkg::ST_RUN) && (hc_r == spm_pkg::spm_half_len(rate) - 4'h1);
  assign sl_rise = sck_s2 & ~sck_d & ~sel_n;
  assign sl_fall = ~sck_s2 & sck_d & ~sel_n;
  assign lead = is_master ? (tick & (sck_r == cpol)) : (cpol ? sl_fall : sl_rise);
  assign trail = is_master ? (tick & (sck_r != cpol)) : (cpol ? sl_rise : sl_fall);
  // Next-state logic of the byte engine
  always_comb
  begin
    st_nxt = st_r; sh_nxt = sh_r; rx_nxt = rx_r; cnt_nxt = cnt_r; hc_nxt = hc_r;
    sck_nxt = sck_r; out_nxt = out_r; lat_nxt = lat_r; done_nxt = 1'b0;
    // Load a byte when idle; master also starts the clock burst
    if (tx_load && st_r == spm_pkg::ST_IDLE)
    begin
      sh_nxt = tx_byte;
      out_nxt = tx_byte[7];
      cnt_nxt = 3'h0;
      hc_nxt = 4'h0;
      sck_nxt = cpol;
      if (is_master)
        st_nxt = spm_pkg::ST_RUN;
    end
    // launch and sample on opposite edges
    if (is_master && st_r == spm_pkg::ST_RUN)
    begin
      hc_nxt = tick ? 4'h0 : hc_r + 4'h1;
      sck_nxt = tick ? ~sck_r : sck_r;
    end
    if (lead)
    begin
      if (cpha)
        out_nxt = sh_r[7];
      else
        lat_nxt = in_s2;
    end
    if (trail)
    begin
      sh_nxt = {sh_r[6:0], cpha ? in_s2 : lat_r};
      cnt_nxt = cnt_r + 3'h1;
      if (cnt_r == spm_pkg::LAST_BIT)
      begin
        rx_nxt = sh_nxt;
        done_nxt = 1'b1;
        st_nxt = is_master ? spm_pkg::ST_WAIT : spm_pkg::ST_IDLE;
      end
    end
    // master keeps select low one half period past the last edge
    if (is_master && st_r == spm_pkg::ST_WAIT)
    begin
      hc_nxt = hc_r + 4'h1;
      if (hc_r == spm_pkg::spm_half_len(rate) - 4'h1)
        st_nxt = spm_pkg::ST_IDLE;
    end
    // Slave drops a partial byte when deselected
    if (!is_master && sel_n)
      cnt_nxt = 3'h0;
  end
  // Engine registers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_r <= spm_pkg::ST_IDLE; sh_r <= spm_pkg::DATA_RST; rx_r <= spm_pkg::DATA_RST;
      cnt_r <= 3'h0; hc_r <= 4'h0; sck_r <= 1'b0; out_r <= 1'b0; lat_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt; sh_r <= sh_nxt; rx_r <= rx_nxt; cnt_r <= cnt_nxt; hc_r <= hc_nxt;
      sck_r <= sck_nxt; out_r <= out_nxt; lat_r <= lat_nxt; done_r <= done_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // master holds select low for the byte
  assign link.far_ss_n_o = (st_r == spm_pkg::ST_IDLE);
  assign link.far_ss_n_oe = is_master;
  // clock idles at cpol outside a burst
  assign link.far_sclk_o = (st_r == spm_pkg::ST_RUN) ? sck_r : cpol;
  assign link.far_sclk_oe = is_master;
  assign link.far_mosi_o = cpha ? out_r : sh_r[7];
  assign link.far_mosi_oe = is_master;
  assign link.far_miso_o = cpha ? out_r : sh_r[7];
  assign link.far_miso_oe = ~is_master & ~sel_n;
  // User answers
  assign rx_byte = rx_r;
  assign rx_done = done_r;
  assign busy = is_master ? (st_r != spm_pkg::ST_IDLE) : (cnt_r != 3'h0);
endmodule : spm_far_end
`default_nettype wire

//--- tb/spm_link_props.sv
// Link checker for the serial port and its far end
`timescale 1ns/1ps
`default_nettype none
module spm_link_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Drive enables and port data out
  input wire logic dev_sclk_oe,
  input wire logic dev_mosi_o,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe,
  input wire logic far_sclk_oe,
  input wire logic far_mosi_oe,
  input wire logic far_miso_oe,
  // Resolved clock line
  input wire logic sclk
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Last samples and mosi change at last edge
  logic sclk_r, oe_r, mosi_r, mchg_r;
  // Edges in burst, cycles since edge, last spacing
  logic [4:0] tog_r, gap_r, sp_r;
  // Port clock edge seen on the line
  logic tog;
  assign tog = dev_sclk_oe && oe_r && (sclk != sclk_r);
  // Burst bookkeeping; sixteen quiet cycles end a burst
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sclk_r <= 1'b0;
      oe_r <= 1'b0;
      mosi_r <= 1'b0;
      mchg_r <= 1'b0;
      tog_r <= 5'h0;
      gap_r <= 5'h0;
      sp_r <= 5'h0;
    end
    else
    begin
      sclk_r <= sclk;
      oe_r <= dev_sclk_oe;
      mosi_r <= dev_mosi_o;
      gap_r <= tog ? 5'h0 : ((gap_r == 5'h1f) ? 5'h1f : gap_r + 5'h1);
      if (tog)
      begin
        tog_r <= tog_r + 5'h1;
        sp_r <= gap_r;
        mchg_r <= (dev_mosi_o != mosi_r);
      end
      else if (gap_r == 5'h10)
        tog_r <= 5'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_sclk_one_drv: assert property (!(dev_sclk_oe && far_sclk_oe))
    else $error("both ends drive the clock");
  a_mosi_one_drv: assert property (!(dev_mosi_oe && far_mosi_oe))
    else $error("both ends drive mosi");
  a_miso_one_drv: assert property (!(dev_miso_oe && far_miso_oe))
    else $error("both ends drive miso");
  a_slave_pins: assert property (dev_miso_oe |-> !dev_sclk_oe && !dev_mosi_oe)
    else $error("slave drives master pins");
  a_master_pins: assert property ($rose(dev_sclk_oe) |-> dev_mosi_oe && !dev_miso_oe)
    else $error("master pins not taken together");
  a_burst_eight: assert property (gap_r == 5'h10 |-> tog_r == 5'h0 || tog_r == 5'h10)
    else $error("burst is not sixteen edges");
  a_burst_max: assert property (tog |-> tog_r < 5'h10)
    else $error("more than sixteen edges");
  a_rate_step: assert property (tog && tog_r != 5'h0 |-> gap_r inside {5'h0, 5'h1, 5'h3, 5'h7})
    else $error("half period not 1, 2, 4 or 8");
  a_rate_even: assert property (tog && tog_r >= 5'h2 |-> gap_r == sp_r)
    else $error("half period varies in burst");
  a_launch_alt: assert property (tog && tog_r != 5'h0 && dev_mosi_o != mosi_r |-> !mchg_r)
    else $error("mosi changed on both edges");
  a_mosi_hold: assert property (dev_mosi_oe && !tog && tog_r != 5'h0 && tog_r != 5'h10
    |-> $stable(dev_mosi_o))
    else $error("mosi moved between edges");
endmodule : spm_link_props
`default_nettype wire

//--- tb/tb_top.sv
// Bench joining the serial port to its far end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Clock, reset, counters
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int i;
  // Register access
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, rd_v;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic owns;
  // Far end controls
  logic f_master = 1'b0;
  logic f_cpol = 1'b0;
  logic f_cpha = 1'b0;
  logic f_sel_n = 1'b1;
  logic f_load = 1'b0;
  logic [1:0] f_rate = 2'h3;
  logic [7:0] f_tx = 8'h00;
  logic [7:0] f_rx;
  logic f_done, f_busy;
  spm_link_if link ();
  spm_port i_spm_port (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .spi_owns_pins(owns), .link(link));
  spm_far_end i_spm_far_end (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .is_master(f_master),
    .cpol(f_cpol), .cpha(f_cpha), .rate(f_rate), .sel_n(f_sel_n), .tx_byte(f_tx),
    .tx_load(f_load), .rx_byte(f_rx), .rx_done(f_done), .busy(f_busy), .link(link));
  spm_link_props i_spm_link_props (.ref_clk(ref_clk), .rstn(rstn),
    .dev_sclk_oe(link.dev_sclk_oe), .dev_mosi_o(link.dev_mosi_o),
    .dev_mosi_oe(link.dev_mosi_oe), .dev_miso_oe(link.dev_miso_oe),
    .far_sclk_oe(link.far_sclk_oe), .far_mosi_oe(link.far_mosi_oe),
    .far_miso_oe(link.far_miso_oe), .sclk(link.sclk));
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      end_of_test();
    end
  end
  // Verdict and end of run
  task automatic end_of_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Compare seen against expected
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Wait n edges, then settle
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask : step
  // One register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask : wr
  // One register read into rd_v
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1;
    rd_v = sfr_rdata;
  endtask : rd
  // Far end byte load pulse
  task automatic pulse_load();
    @(posedge ref_clk);
    f_load <= 1'b1;
    @(posedge ref_clk);
    f_load <= 1'b0;
  endtask : pulse_load
  // Poll control until done flag, bounded
  task automatic wait_done();
    int n;
    for (n = 0; n < 300; n++)
    begin
      rd(spm_pkg::ADDR_CTRL);
      if (rd_v[7] === 1'b1)
        break;
    end
  endtask : wait_done
  // Port as master; mode is polarity, phase, rate
  task automatic xfer_m(input logic [3:0] mode, input logic [7:0] dtx, input logic [7:0] ftx,
    input logic coll);
    logic s;
    int h;
    // Disable first so a new idle level is not seen as a clock edge
    wr(spm_pkg::ADDR_CTRL, {4'h1, mode});
    wr(spm_pkg::ADDR_CTRL, {4'h3, mode});
    // Select the far end only once the idle clock level has passed its flops
    repeat (4) @(posedge ref_clk);
    f_master <= 1'b0;
    f_cpol <= mode[3];
    f_cpha <= mode[2];
    f_sel_n <= 1'b0;
    f_tx <= ftx;
    pulse_load();
    wr(spm_pkg::ADDR_DATA, dtx);
    step(1);
    s = link.sclk;
    for (h = 0; h < 40 && link.sclk === s; h++) step(1);
    s = link.sclk;
    for (h = 0; h < 40 && link.sclk === s; h++) step(1);
    check(8'(h), 8'h01 << mode[1:0]);
    // Colliding write lands mid-burst
    if (coll)
      wr(spm_pkg::ADDR_DATA, ~dtx);
    wait_done();
    check(rd_v, {1'b1, coll, 2'h3, mode});
    if (coll)
    begin
      wr(spm_pkg::ADDR_CTRL, {4'h3, mode});
      rd(spm_pkg::ADDR_CTRL);
      check(rd_v, {4'h3, mode});
    end
    rd(spm_pkg::ADDR_DATA);
    if (mode[1:0] == 2'h3)
      check(rd_v, ftx);
    rd(spm_pkg::ADDR_CTRL);
    check(rd_v, {4'h3, mode});
    f_sel_n <= 1'b1;
    step(30);
    if (mode[1:0] == 2'h3)
      check(f_rx, dtx);
  endtask : xfer_m
  // Port as slave, far end as master
  task automatic xfer_s(input logic [1:0] pm, input logic [7:0] dtx, input logic [7:0] ftx);
    wr(spm_pkg::ADDR_CTRL, {4'h2, pm, 2'h0});
    wr(spm_pkg::ADDR_DATA, dtx);
    f_master <= 1'b1;
    f_cpol <= pm[1];
    f_cpha <= pm[0];
    f_tx <= ftx;
    pulse_load();
    wait_done();
    check(rd_v & 8'hfe, {4'ha, pm, 2'h0});
    step(30);
    rd(spm_pkg::ADDR_CTRL);
    check({7'h0, rd_v[0]}, {7'h0, link.ss_n});
    rd(spm_pkg::ADDR_DATA);
    check(rd_v, ftx);
    check(f_rx, dtx);
  endtask : xfer_s
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(spm_pkg::ADDR_CTRL);
    // Role bit clear means slave: bit 0 shows the pulled-up select line
    check(rd_v, spm_pkg::CTRL_RST | 8'h01);
    rd(spm_pkg::ADDR_DATA);
    check(rd_v, spm_pkg::DATA_RST);
    check({7'h0, owns}, 8'h00);
    for (i = 0; i < 4; i++) xfer_m({i[1:0], 2'h3}, 8'ha5 ^ 8'(i), 8'h3c + 8'(i), i == 2);
    check({7'h0, owns}, 8'h01);
    for (i = 0; i < 3; i++) xfer_m({2'h1, i[1:0]}, 8'h81, 8'h7e, 1'b0);
    rd(8'h10);
    check(rd_v, 8'h00);
    for (i = 0; i < 4; i++) xfer_s(i[1:0], 8'h96 + 8'(i), 8'h0f ^ 8'(i));
    wr(spm_pkg::ADDR_CTRL, 8'h10);
    step(2);
    check({7'h0, owns}, 8'h00);
    check({7'h0, link.dev_sclk_oe}, 8'h00);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
